//--- design/adc_seq_pkg.sv
// Package of constants and types for the SAR converter sequencer
package adc_seq_pkg;

  // ==========================================================
  // Clock select encodings
  localparam logic [1:0] CLK_DIV2  = 2'h0;
  localparam logic [1:0] CLK_DIV8  = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [1:0] CLK_RC    = 2'h3;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int RC_PERIOD_NS   = 4000;
  localparam int RC_HALF_CYCLES =
    (RC_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_DIV2      = 1;
  localparam int HALF_DIV8      = 4;
  localparam int HALF_DIV32     = 16;
  // Conversion is 19 half bit periods (9.5 periods)
  localparam int CONV_HALVES    = 19;
  // Three half periods before the first bit decision
  localparam int FIRST_BIT_HALF = 3;
  localparam int HOLDOFF_HALVES = 4;
  localparam int RESULT_WIDTH   = 8;
  localparam int PIN_COUNT      = 8;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  typedef enum logic [1:0] {
    IDLE,
    ACQUIRE,
    CONVERT,
    HOLDOFF
  } seq_state_type;

endpackage

//--- design/bit_clock_gen.sv
// Bit period tick generator: emits a pulse each half bit period
`timescale 1ns/10ps
module bit_clock_gen (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic [1:0] conv_clock_select,
  output logic            half_tick
);

  logic [11:0] count;
  logic [11:0] half_len;
  logic        at_end;

  assign half_len =
    (conv_clock_select == adc_seq_pkg::CLK_DIV2)  ?
      12'(adc_seq_pkg::HALF_DIV2) :
    (conv_clock_select == adc_seq_pkg::CLK_DIV8)  ?
      12'(adc_seq_pkg::HALF_DIV8) :
    (conv_clock_select == adc_seq_pkg::CLK_DIV32) ?
      12'(adc_seq_pkg::HALF_DIV32) :
      12'(adc_seq_pkg::RC_HALF_CYCLES);
  assign at_end = (count + 12'h001 >= half_len);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count     <= 12'h000;
      half_tick <= 1'b0;
    end else if (!run) begin
      count     <= 12'h000;
      half_tick <= 1'b0;
    end else begin
      count     <= at_end ? 12'h000 : count + 12'h001;
      half_tick <= at_end;
    end
  end

endmodule

//--- design/sar_adc_sequencer.sv
// Sequencer for an 8-bit successive-approximation converter
//
// Overview of operation
// - A conversion lasts nine and a half bit periods from start to done.
// - Bit period is 2, 8 or 32 clocks, or the internal RC source.
// - RC source gives about four microseconds per bit, counted as system clocks of 10 ns.
// - After completion wait two bit periods, hold capacitor disconnected.
// - Clearing go/done during a conversion aborts it at once.
// - An aborted conversion leaves the result register unchanged; an abort in the conv_end cycle still loads it.
// - After abort, wait two bit periods then acquire selected channel; code waits three halves plus the rest of the interrupted one.
// - Port reads return zero for pins configured as analog inputs.
// - An output pin selected for conversion converts its driven level.
// - A digital input pin selected still converts its analog level.
// - Acquisition is the same whatever resolution software uses.
// - Bits after an illegal clock change may be wrong; earlier stay.
// - On completion load result, clear go/done, set done flag.
`timescale 1ns/10ps
module sar_adc_sequencer (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       converter_on,
  input  wire logic [1:0] conv_clock_select,
  input  wire logic [2:0] channel_select,
  input  wire logic       go_set,
  input  wire logic       go_clear,
  input  wire logic       result_write,
  input  wire logic [7:0] result_write_data,
  input  wire logic       done_flag_clear,
  input  wire logic [7:0] analog_pin_mask,
  input  wire logic [7:0] pin_direction_bits,
  input  wire logic [7:0] pin_output_level,
  input  wire logic [7:0] port_pin_level,
  input  wire logic       comparator_high,
  output logic [7:0]      port_read_data,
  output logic            go_done,
  output logic [7:0]      conv_result,
  output logic            conv_done_flag,
  output logic            hold_connect,
  output logic            dac_digital_drive,
  output logic [7:0]      dac_code,
  output logic [2:0]      sampled_channel,
  output logic            busy
);

  // ==========================================================
  // Comparator input synchroniser (three stages)
  logic       cmp_s1;
  logic       cmp_s2;
  logic       cmp_s3;
  logic       cmp_level;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_s1    <= 1'b0;
      cmp_s2    <= 1'b0;
      cmp_s3    <= 1'b0;
      cmp_level <= 1'b0;
    end else begin
      cmp_s1 <= comparator_high;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      if (cmp_s2 == cmp_s3) begin
        cmp_level <= cmp_s3;
      end
    end
  end

  // ==========================================================
  // Bit period timing
  adc_seq_pkg::seq_state_type state;
  adc_seq_pkg::seq_state_type next_state;
  logic [4:0] halves;
  logic       half_tick;
  logic       tick_run;

  assign tick_run = converter_on &&
                    (state == adc_seq_pkg::CONVERT ||
                     state == adc_seq_pkg::HOLDOFF);

  // RC selection counts a fixed period from the system clock
  bit_clock_gen u_bit_clock (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .run               (tick_run),
    .conv_clock_select (conv_clock_select),
    .half_tick         (half_tick)
  );

  // ==========================================================
  // Sequencing decode
  logic       abort_req;
  logic       conv_end;
  logic       holdoff_end;
  logic       bit_decide;
  logic [2:0] bit_index;
  logic [7:0] trial;
  logic       pin_is_output;

  assign abort_req   = (state == adc_seq_pkg::CONVERT) &&
                       (go_clear || !converter_on);
  assign conv_end    = (state == adc_seq_pkg::CONVERT) && half_tick &&
                       (halves == 5'(adc_seq_pkg::CONV_HALVES - 1));
  assign holdoff_end = (state == adc_seq_pkg::HOLDOFF) && half_tick &&
                       (halves == 5'(adc_seq_pkg::HOLDOFF_HALVES - 1));
  // Decide one bit at each odd half from the third, MSB first
  assign bit_decide  = (state == adc_seq_pkg::CONVERT) && half_tick &&
                       !abort_req &&
                       (halves >= 5'(adc_seq_pkg::FIRST_BIT_HALF)) &&
                       halves[0] &&
                       (halves < 5'(adc_seq_pkg::FIRST_BIT_HALF + 16));
  assign bit_index   = 3'(7 - ((halves - 5'(adc_seq_pkg::FIRST_BIT_HALF))
                           >> 1));
  // Only the bit under test, so kept upper bits survive a reject
  assign trial       = 8'h80 >> (3'h7 - bit_index);
  assign pin_is_output = !pin_direction_bits[channel_select];

  always_comb begin
    next_state = state;
    unique case (state)
      adc_seq_pkg::IDLE: begin
        if (converter_on) begin
          next_state = adc_seq_pkg::ACQUIRE;
        end
      end
      adc_seq_pkg::ACQUIRE: begin
        // Acquisition lasts as long as software holds off go
        if (!converter_on) begin
          next_state = adc_seq_pkg::IDLE;
        end else if (go_set) begin
          next_state = adc_seq_pkg::CONVERT;
        end
      end
      adc_seq_pkg::CONVERT: begin
        if (abort_req || conv_end) begin
          next_state = adc_seq_pkg::HOLDOFF;
        end
      end
      adc_seq_pkg::HOLDOFF: begin
        if (!converter_on) begin
          next_state = adc_seq_pkg::IDLE;
        end else if (holdoff_end) begin
          next_state = adc_seq_pkg::ACQUIRE;
        end
      end
    endcase
  end

  // ==========================================================
  // State, half-period count and approximation register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= adc_seq_pkg::IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      halves <= 5'h00;
    end else if (next_state != state) begin
      halves <= 5'h00;
    end else if (half_tick) begin
      halves <= halves + 5'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dac_code <= 8'h00;
    end else if (state == adc_seq_pkg::ACQUIRE) begin
      dac_code <= 8'h80;
    end else if (bit_decide) begin
      // Keep the trial bit if input is above, then try the next one
      dac_code <= (cmp_level ? dac_code : dac_code & ~trial) |
                  ((bit_index != 3'h0) ? (trial >> 1) : 8'h00);
    end
  end

  // ==========================================================
  // Result, go/done and done flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_result <= adc_seq_pkg::RESULT_RESET;
    end else if (conv_end) begin
      conv_result <= dac_code;
    end else if (result_write) begin
      conv_result <= result_write_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      go_done <= 1'b0;
    end else if (conv_end || abort_req) begin
      go_done <= 1'b0;
    end else if (state == adc_seq_pkg::ACQUIRE && go_set && converter_on) begin
      go_done <= 1'b1;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_done_flag <= 1'b0;
    end else if (conv_end) begin
      conv_done_flag <= 1'b1;
    end else if (done_flag_clear) begin
      conv_done_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Analog front end controls
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_connect      <= 1'b0;
      dac_digital_drive <= 1'b0;
      sampled_channel   <= 3'h0;
      port_read_data    <= 8'h00;
    end else begin
      hold_connect      <= (next_state == adc_seq_pkg::ACQUIRE);
      dac_digital_drive <= pin_is_output;
      sampled_channel   <= channel_select;
      port_read_data    <= port_pin_level & ~analog_pin_mask;
    end
  end

  assign busy = (state == adc_seq_pkg::CONVERT) ||
                (state == adc_seq_pkg::HOLDOFF);

endmodule

//--- test/sar_adc_monitor.sv
// Port checker for the converter sequencer
`timescale 1ns/10ps
module sar_adc_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       converter_on,
  input wire logic [1:0] conv_clock_select,
  input wire logic       go_set,
  input wire logic       go_clear,
  input wire logic       result_write,
  input wire logic       done_flag_clear,
  input wire logic [7:0] analog_pin_mask,
  input wire logic [7:0] port_pin_level,
  input wire logic [7:0] port_read_data,
  input wire logic       go_done,
  input wire logic [7:0] conv_result,
  input wire logic       conv_done_flag,
  input wire logic       hold_connect,
  input wire logic       busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ======================================
  // Cycles spent with a conversion running
  logic [7:0] conv_cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) conv_cnt <= 8'h00;
    else if (go_done) conv_cnt <= conv_cnt + 8'h01;
    else conv_cnt <= 8'h00;
  end
  // ======================================
  // One-cycle history for the normal completion event
  logic go_done_d;
  logic go_clear_d;
  logic conv_on_d;
  logic normal_end;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      go_done_d  <= 1'b0;
      go_clear_d <= 1'b0;
      conv_on_d  <= 1'b0;
    end else begin
      go_done_d  <= go_done;
      go_clear_d <= go_clear;
      conv_on_d  <= converter_on;
    end
  end
  assign normal_end = go_done_d && !go_done && !go_clear_d && conv_on_d;
  property p_start;
    go_set && hold_connect && converter_on && !go_clear |=> go_done;
  endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_len;
    normal_end && conv_clock_select == adc_seq_pkg::CLK_DIV2
      |-> conv_cnt >= 8'h11 && conv_cnt <= 8'h16;
  endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_done;
    normal_end |-> conv_done_flag;
  endproperty
  a_done: assert property (p_done) else $error("flag not set");
  property p_flag_hold;
    conv_done_flag && !done_flag_clear |=> conv_done_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  property p_abort;
    go_done && go_clear |=> !go_done;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_abort_keep;
    go_done && go_clear && !result_write && !done_flag_clear
      |=> $stable(conv_result) && $stable(conv_done_flag);
  endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("changed");
  property p_holdoff;
    $fell(go_done) |-> !hold_connect [*3];
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("early hold");
  property p_busy;
    busy |-> !hold_connect;
  endproperty
  a_busy: assert property (p_busy) else $error("hold in use");
  property p_port;
    1'b1 |=> port_read_data == ($past(port_pin_level)
                               & ~$past(analog_pin_mask));
  endproperty
  a_port: assert property (p_port) else $error("port read");
  c_done: cover property (normal_end);
  c_abort: cover property (go_done && go_clear);
  c_acq: cover property ($rose(hold_connect));
endmodule
bind sar_adc_sequencer sar_adc_monitor u_mon (.clk, .sys_rst,
  .converter_on, .conv_clock_select, .go_set, .go_clear, .result_write,
  .done_flag_clear, .analog_pin_mask, .port_pin_level, .port_read_data,
  .go_done, .conv_result, .conv_done_flag, .hold_connect, .busy);

//--- test/sar_adc_sequencer_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
module sar_adc_sequencer_tb;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       converter_on, go_set, go_clear, result_write;
  logic       done_flag_clear, comparator_high;
  logic       go_done, conv_done_flag, hold_connect, dac_digital_drive;
  logic       busy;
  logic [1:0] conv_clock_select;
  logic [2:0] channel_select, sampled_channel;
  logic [7:0] result_write_data, analog_pin_mask, pin_direction_bits;
  logic [7:0] pin_output_level, port_pin_level, port_read_data;
  logic [7:0] conv_result, dac_code;
  logic [7:0] vin;
  int         err_total = 0;
  int         check_count = 0;
  int         n, m, h;
  int         half_tab [4] = '{adc_seq_pkg::HALF_DIV2,
    adc_seq_pkg::HALF_DIV8, adc_seq_pkg::HALF_DIV32,
    adc_seq_pkg::RC_HALF_CYCLES};
  localparam int CH = adc_seq_pkg::CONV_HALVES;
  localparam int HH = adc_seq_pkg::HOLDOFF_HALVES;
  // Acquisition wait of 12 us before each start
  localparam int ACQ_CYCLES = 1200;

  always #5 clk = ~clk;

  // Analog input above the trial code drives the comparator high
  always @(negedge clk) begin
    comparator_high <= (dac_code <= vin);
  end

  sar_adc_sequencer u_dut (.clk, .sys_rst, .converter_on,
    .conv_clock_select, .channel_select, .go_set, .go_clear, .result_write,
    .result_write_data, .done_flag_clear, .analog_pin_mask,
    .pin_direction_bits, .pin_output_level, .port_pin_level,
    .comparator_high, .port_read_data, .go_done, .conv_result,
    .conv_done_flag, .hold_connect, .dac_digital_drive, .dac_code,
    .sampled_channel, .busy);

  // ======================================
  // Tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Counts cycles until conversion end or until acquisition starts
  task automatic wait_for(input bit conv_end, output int cnt);
    cnt = 0;
    while ((conv_end ? go_done !== 1'b0 : hold_connect !== 1'b1)
           && cnt < 5000) begin
      @(negedge clk);
      cnt++;
    end
    if (cnt >= 5000) begin
      err_total++;
      final_report();
    end
  endtask

  task automatic start_conv;
    wait_for(1'b0, m);
    repeat (ACQ_CYCLES) @(negedge clk);
    go_set = 1'b1;
    @(negedge clk);
    go_set = 1'b0;
  endtask

  // ======================================
  // Tests
  initial begin
    {converter_on, go_set, go_clear, result_write} = '0;
    {done_flag_clear, conv_clock_select} = '0;
    vin = 8'h00;
    channel_select = 3'h2;
    {result_write_data, analog_pin_mask, pin_direction_bits} = '0;
    pin_output_level = 8'h55;
    port_pin_level = 8'hFF;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    check(conv_result, adc_seq_pkg::RESULT_RESET);
    check({7'h00, conv_done_flag}, 8'h00);
    analog_pin_mask = 8'h0F;
    repeat (2) @(negedge clk);
    check(port_read_data, 8'hF0);
    analog_pin_mask = 8'hFF;
    repeat (2) @(negedge clk);
    check(port_read_data, 8'h00);
    $display("test port_mask done");
    converter_on = 1'b1;
    for (int i = 0; i < 4; i++) begin
      h = half_tab[i];
      conv_clock_select = i[1:0];
      vin = i[0] ? 8'hFF : 8'h00;
      pin_direction_bits = i[1] ? 8'h00 : 8'hFF;
      start_conv();
      repeat (2) @(negedge clk);
      check({7'h00, dac_digital_drive}, {7'h00, i[1]});
      wait_for(1'b1, n);
      check(conv_result, i[0] ? 8'hFF : 8'h00);
      check({7'h00, conv_done_flag}, 8'h01);
      check({7'h00, n >= (CH - 1) * h && n <= (CH + 1) * h + 4}, 8'h01);
      wait_for(1'b0, m);
      check({7'h00, m >= HH * h - 1 && m <= HH * h + 4}, 8'h01);
      done_flag_clear = 1'b1;
      @(negedge clk);
      done_flag_clear = 1'b0;
      @(negedge clk);
      check({7'h00, conv_done_flag}, 8'h00);
    end
    $display("test clock_select done");
    vin = 8'hA5;
    channel_select = 3'h5;
    conv_clock_select = adc_seq_pkg::CLK_DIV32;
    start_conv();
    check({5'h00, sampled_channel}, 8'h05);
    wait_for(1'b1, n);
    check(conv_result, 8'hA5);
    start_conv();
    repeat (200) @(negedge clk);
    conv_clock_select = adc_seq_pkg::CLK_DIV8;
    wait_for(1'b1, n);
    check({4'h0, conv_result[7:4]}, 8'h0A);
    done_flag_clear = 1'b1;
    @(negedge clk);
    done_flag_clear = 1'b0;
    @(negedge clk);
    check({7'h00, conv_done_flag}, 8'h00);
    $display("test approximation done");
    result_write_data = 8'h5A;
    result_write = 1'b1;
    @(negedge clk);
    result_write = 1'b0;
    @(negedge clk);
    check(conv_result, 8'h5A);
    conv_clock_select = adc_seq_pkg::CLK_DIV8;
    h = adc_seq_pkg::HALF_DIV8;
    start_conv();
    repeat (20) @(negedge clk);
    go_clear = 1'b1;
    @(negedge clk);
    go_clear = 1'b0;
    check({7'h00, go_done}, 8'h00);
    check(conv_result, 8'h5A);
    check({7'h00, conv_done_flag}, 8'h00);
    wait_for(1'b0, m);
    check({7'h00, m >= HH * h - 2 && m <= HH * h + 4}, 8'h01);
    $display("test abort done");
    final_report();
  end
endmodule
